// ==== design/pbpc_pkg.sv ====
// Package for the port B / port C alternate-function override logic.
// Assumes a single core clock; all override outputs are per-pin vectors.
package pbpc_pkg;
   localparam int PBPC_PORT_W = 8;
   localparam int PBPC_MASK_W = 3;
   // Port B pin positions
   localparam int PBPC_B_CNT0 = 0;
   localparam int PBPC_B_CNT1 = 1;
   localparam int PBPC_B_CMP_POS = 2;
   localparam int PBPC_B_CMP_NEG = 3;
   localparam int PBPC_B_SEL = 4;
   localparam int PBPC_B_MOSI = 5;
   localparam int PBPC_B_MISO = 6;
   localparam int PBPC_B_SCK = 7;
   // Mask limits per port C pin, bit 0 first
   localparam logic [2:0] PBPC_LIM_C0 = 3'h7;
   localparam logic [2:0] PBPC_LIM_C1 = 3'h7;
   localparam logic [2:0] PBPC_LIM_C2 = 3'h6;
   localparam logic [2:0] PBPC_LIM_C3 = 3'h5;
   localparam logic [2:0] PBPC_LIM_C4 = 3'h4;
   localparam logic [2:0] PBPC_LIM_C5 = 3'h3;
   localparam logic [2:0] PBPC_LIM_C6 = 3'h2;
   localparam logic [2:0] PBPC_LIM_C7 = 3'h1;
   // Value after reset of the registered outputs
   localparam logic [7:0] PBPC_RST_BYTE = 8'h00;
   localparam logic PBPC_RST_BIT = 1'b0;
endpackage

// ==== design/pbpc_addr_pin.sv ====
// One port C address pin: override enable from the memory enable and mask.
// Assumes mask and enable are stable core-clock signals.
`timescale 1ns/100ps
module pbpc_addr_pin
   import pbpc_pkg::*;
#(
   parameter logic [2:0] LIMIT = 3'h7
) (
   input wire logic ext_mem_enable,
   input wire logic [2:0] ext_mem_high_addr_mask,
   output logic claim
);
   // Pin belongs to the memory bus while the mask is below its limit
   assign claim = ext_mem_enable && (ext_mem_high_addr_mask < LIMIT);
endmodule

// ==== design/pbpc_override.sv ====
// Override logic for port B peripherals and port C high address bits.
// Assumes pin inputs come from pads (synchronised here) and all peripheral
// signals are on sys_clk. Override outputs are registered, one cycle late.
`timescale 1ns/100ps
// Operation
// RULE_01: Software sets the port B bit 0 direction before compare appears.
// RULE_02: Port B bit 0 value override follows timer 0 compare enable.
// RULE_03: Port B bits 0 and 1 inputs feed timer 0 and 1 counts.
// RULE_04: MISO input feeds SPI master receive; override carries slave send.
// RULE_05: MOSI override carries master send; input feeds slave; SCK both.
// RULE_06: SPI pins: pull-up value latch AND disable; enables SPI and master.
// RULE_07: Port B bits 3 and 2 go to comparator; bit 3 direction value 1.
// RULE_08: Port C bits 7..0 carry external address bits 15..8.
// RULE_09: Port C bits 7..4 claimed when enabled and mask below 1..4.
// RULE_10: Port C bits 3..0 claimed when mask below 5,6,7,7.
// RULE_11: One enable bit claims pins; the mask releases upper pins.
module pbpc_override
   import pbpc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic serial_periph_enable,
   input wire logic master_select,
   input wire logic global_pullup_disable,
   input wire logic ext_mem_enable,
   input wire logic [2:0] ext_mem_high_addr_mask,
   input wire logic [7:0] portb_latch,
   input wire logic [7:0] portb_pin,
   input wire logic [7:0] portc_pin,
   input wire logic timer0_compare_enable,
   input wire logic timer0_compare_output,
   input wire logic spi_clock_output,
   input wire logic spi_slave_tx,
   input wire logic spi_master_tx,
   input wire logic [7:0] ext_addr_high,
   output logic [7:0] portb_pullup_override_enable,
   output logic [7:0] portb_pullup_override_value,
   output logic [7:0] portb_direction_override_enable,
   output logic [7:0] portb_direction_override_value,
   output logic [7:0] portb_pin_value_override_enable,
   output logic [7:0] portb_pin_value_override_value,
   output logic [7:0] portb_input_enable_override_enable,
   output logic [7:0] portb_input_enable_override_value,
   output logic [7:0] portc_pullup_override_enable,
   output logic [7:0] portc_pullup_override_value,
   output logic [7:0] portc_direction_override_enable,
   output logic [7:0] portc_direction_override_value,
   output logic [7:0] portc_pin_value_override_enable,
   output logic [7:0] portc_pin_value_override_value,
   output logic [7:0] portc_input_enable_override_enable,
   output logic [7:0] portc_input_enable_override_value,
   output logic timer0_count_input,
   output logic timer1_count_input,
   output logic spi_master_rx,
   output logic spi_slave_rx,
   output logic spi_clock_input,
   output logic spi_slave_select_in,
   output logic comparator_pos_input,
   output logic comparator_neg_input
);
   logic [7:0] pb_meta_r;
   logic [7:0] pb_sync_r;
   logic [7:0] pc_meta_r;
   logic [7:0] pc_sync_r;
   logic [7:0] pc_claim;
   logic spi_own;
   logic [7:0] b_pue_nxt, b_puv_nxt, b_dde_nxt, b_ddv_nxt;
   logic [7:0] b_pve_nxt, b_pvv_nxt;
   logic [7:0] b_pue_r, b_puv_r, b_dde_r, b_ddv_r, b_pve_r, b_pvv_r;
   logic [7:0] c_claim_r, c_addr_r;

   // Pads are asynchronous; two flops before the digital paths read them
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pb_meta_r <= PBPC_RST_BYTE;
         pb_sync_r <= PBPC_RST_BYTE;
         pc_meta_r <= PBPC_RST_BYTE;
         pc_sync_r <= PBPC_RST_BYTE;
      end else begin
         pb_meta_r <= portb_pin;
         pb_sync_r <= pb_meta_r;
         pc_meta_r <= portc_pin;
         pc_sync_r <= pc_meta_r;
      end
   end

   // Peripheral input paths from synchronised pads
   assign timer0_count_input = pb_sync_r[PBPC_B_CNT0]; // RULE_03
   assign timer1_count_input = pb_sync_r[PBPC_B_CNT1]; // RULE_03
   assign spi_master_rx = pb_sync_r[PBPC_B_MISO]; // RULE_04
   assign spi_slave_rx = pb_sync_r[PBPC_B_MOSI]; // RULE_05
   assign spi_clock_input = pb_sync_r[PBPC_B_SCK]; // RULE_05
   assign spi_slave_select_in = pb_sync_r[PBPC_B_SEL];
   // Comparator sees the raw pad: analog path, not sampled
   assign comparator_pos_input = portb_pin[PBPC_B_CMP_POS]; // RULE_07
   assign comparator_neg_input = portb_pin[PBPC_B_CMP_NEG]; // RULE_07

   assign spi_own = serial_periph_enable && master_select; // RULE_06

   // Port B override terms; bits without an entry stay zero
   always_comb begin
      b_pue_nxt = 8'h00;
      b_puv_nxt = 8'h00;
      b_dde_nxt = 8'h00;
      b_ddv_nxt = 8'h00;
      b_pve_nxt = 8'h00;
      b_pvv_nxt = 8'h00;
      // Latch AND the disable term itself, not its inverse
      b_pue_nxt[7:4] = {4{spi_own}}; // RULE_06
      b_dde_nxt[7:4] = {4{spi_own}}; // RULE_06
      b_puv_nxt[7:4] = portb_latch[7:4] &
         {4{global_pullup_disable}}; // RULE_06
      b_pve_nxt[7:5] = {3{spi_own}}; // RULE_05
      b_pvv_nxt[PBPC_B_SCK] = spi_clock_output; // RULE_05
      b_pvv_nxt[PBPC_B_MISO] = spi_slave_tx; // RULE_04
      b_pvv_nxt[PBPC_B_MOSI] = spi_master_tx; // RULE_05
      // Value 1 with enable 0: no effect unless enable rises
      b_ddv_nxt[PBPC_B_CMP_NEG] = 1'b1; // RULE_07
      // Direction left to software; pin drives only if it set it
      b_pve_nxt[PBPC_B_CNT0] = timer0_compare_enable; // RULE_02 RULE_01
      b_pvv_nxt[PBPC_B_CNT0] = timer0_compare_output; // RULE_02
   end

   // Per-pin claim of port C by the memory bus
   pbpc_addr_pin #(.LIMIT(PBPC_LIM_C0)) u_c0 (.ext_mem_enable(ext_mem_enable),
      .ext_mem_high_addr_mask(ext_mem_high_addr_mask), .claim(pc_claim[0]));
   pbpc_addr_pin #(.LIMIT(PBPC_LIM_C1)) u_c1 (.ext_mem_enable(ext_mem_enable),
      .ext_mem_high_addr_mask(ext_mem_high_addr_mask), .claim(pc_claim[1]));
   pbpc_addr_pin #(.LIMIT(PBPC_LIM_C2)) u_c2 (.ext_mem_enable(ext_mem_enable),
      .ext_mem_high_addr_mask(ext_mem_high_addr_mask), .claim(pc_claim[2]));
   pbpc_addr_pin #(.LIMIT(PBPC_LIM_C3)) u_c3 (.ext_mem_enable(ext_mem_enable),
      .ext_mem_high_addr_mask(ext_mem_high_addr_mask), .claim(pc_claim[3]));
   pbpc_addr_pin #(.LIMIT(PBPC_LIM_C4)) u_c4 (.ext_mem_enable(ext_mem_enable),
      .ext_mem_high_addr_mask(ext_mem_high_addr_mask), .claim(pc_claim[4]));
   pbpc_addr_pin #(.LIMIT(PBPC_LIM_C5)) u_c5 (.ext_mem_enable(ext_mem_enable),
      .ext_mem_high_addr_mask(ext_mem_high_addr_mask), .claim(pc_claim[5]));
   pbpc_addr_pin #(.LIMIT(PBPC_LIM_C6)) u_c6 (.ext_mem_enable(ext_mem_enable),
      .ext_mem_high_addr_mask(ext_mem_high_addr_mask), .claim(pc_claim[6]));
   pbpc_addr_pin #(.LIMIT(PBPC_LIM_C7)) u_c7 (.ext_mem_enable(ext_mem_enable),
      .ext_mem_high_addr_mask(ext_mem_high_addr_mask), .claim(pc_claim[7]));

   // Port B override register; data outputs come from flops
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         b_pue_r <= PBPC_RST_BYTE;
         b_puv_r <= PBPC_RST_BYTE;
         b_dde_r <= PBPC_RST_BYTE;
         b_ddv_r <= PBPC_RST_BYTE;
         b_pve_r <= PBPC_RST_BYTE;
         b_pvv_r <= PBPC_RST_BYTE;
      end else begin
         b_pue_r <= b_pue_nxt;
         b_puv_r <= b_puv_nxt;
         b_dde_r <= b_dde_nxt;
         b_ddv_r <= b_ddv_nxt;
         b_pve_r <= b_pve_nxt;
         b_pvv_r <= b_pvv_nxt;
      end
   end

   // Port C claim and address, one flop; address bit n+8 on pin n
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         c_claim_r <= PBPC_RST_BYTE;
         c_addr_r <= PBPC_RST_BYTE;
      end else begin
         c_claim_r <= pc_claim; // RULE_09 RULE_10 RULE_11
         c_addr_r <= ext_addr_high; // RULE_08
      end
   end

   assign portb_pullup_override_enable = b_pue_r;
   assign portb_pullup_override_value = b_puv_r;
   assign portb_direction_override_enable = b_dde_r;
   assign portb_direction_override_value = b_ddv_r;
   assign portb_pin_value_override_enable = b_pve_r;
   assign portb_pin_value_override_value = b_pvv_r;
   assign portb_input_enable_override_enable = 8'h00;
   assign portb_input_enable_override_value = 8'h00;
   // Claimed pins: output, pull-up off, value is address
   assign portc_pullup_override_enable = c_claim_r; // RULE_09
   assign portc_pullup_override_value = 8'h00; // RULE_09
   assign portc_direction_override_enable = c_claim_r; // RULE_10
   assign portc_direction_override_value = 8'hff; // RULE_10
   assign portc_pin_value_override_enable = c_claim_r; // RULE_09
   assign portc_pin_value_override_value = c_addr_r; // RULE_08
   assign portc_input_enable_override_enable = 8'h00; // RULE_10
   assign portc_input_enable_override_value = 8'h00;

   // Antecedents sample rst_b, except in chk_pc_release, chk_pc_off, chk_pb_cnt_in and chk_pb_cmp_pin: the edge of release still sees reset held
   chk_pc_claim_mask: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rst_b && ext_mem_enable && ext_mem_high_addr_mask == 3'h0 |=>
      portc_pin_value_override_enable == 8'hff) // RULE_09
      else $error("port C not fully claimed at mask 0");
   chk_pc_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ext_mem_enable && ext_mem_high_addr_mask == 3'h7 |=>
      portc_pin_value_override_enable == 8'h00) // RULE_10
      else $error("port C not released at mask 7");
   chk_pc_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !ext_mem_enable |=> portc_direction_override_enable == 8'h00) // RULE_11
      else $error("port C claimed with memory disabled");
   chk_pc_addr: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rst_b |=>
      portc_pin_value_override_value == $past(ext_addr_high)) // RULE_08
      else $error("address bits not on port C");
   chk_pc_mid: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rst_b && ext_mem_enable && ext_mem_high_addr_mask == 3'h4 |=>
      portc_pullup_override_enable == 8'h0f) // RULE_10
      else $error("mask 4 claim wrong");
   chk_pb_cmp: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rst_b && timer0_compare_enable |=>
      portb_pin_value_override_enable[0] &&
      portb_pin_value_override_value[0] == $past(timer0_compare_output)
      && !portb_direction_override_enable[0]) // RULE_02
      else $error("compare output not on port B bit 0");
   chk_pb_spi_en: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rst_b && serial_periph_enable && master_select |=>
      portb_direction_override_enable[7:4] == 4'hf &&
      portb_direction_override_value[7:4] == 4'h0) // RULE_06
      else $error("SPI direction override wrong");
   chk_pb_pullv: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rst_b |=> portb_pullup_override_value[7:4] ==
      ($past(portb_latch[7:4]) & {4{$past(global_pullup_disable)}})) // RULE_06
      else $error("SPI pull-up value wrong");
   chk_pb_miso: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rst_b |=> portb_pin_value_override_value[6] == $past(spi_slave_tx) &&
      portb_pin_value_override_value[5] == $past(spi_master_tx)) // RULE_04
      else $error("MISO or MOSI value path wrong");
   chk_pb_cnt_in: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ##2 timer1_count_input == $past(portb_pin[1], 2)) // RULE_03
      else $error("timer 1 count input not from pad");
   chk_pb_cmp_pin: assert property (@(posedge sys_clk) disable iff (!rst_b)
      portb_direction_override_value[3] == 1'b1 ||
      $past(!rst_b)) // RULE_07
      else $error("bit 3 direction value not one");
   cov_spi_master: cover property (@(posedge sys_clk) disable iff (!rst_b)
      serial_periph_enable && master_select ##1 spi_slave_tx);
   cov_mem_partial: cover property (@(posedge sys_clk) disable iff (!rst_b)
      ext_mem_enable && ext_mem_high_addr_mask == 3'h3);
   cov_cmp_out: cover property (@(posedge sys_clk) disable iff (!rst_b)
      timer0_compare_enable ##1 timer0_compare_output);
endmodule

// ==== verif/pbpc_periph_model.sv ====
// Model of the peripherals that feed the port B / port C override logic.
// Assumes the bench sets a pattern and the bit 0 direction on sys_clk.
`timescale 1ns/100ps
module pbpc_periph_model (
   input wire logic sys_clk,
   input wire logic [7:0] pattern,
   input wire logic portb_bit0_direction,
   input wire logic compare_request,
   output logic timer0_compare_enable,
   output logic timer0_compare_output,
   output logic spi_clock_output,
   output logic spi_slave_tx,
   output logic spi_master_tx,
   output logic [7:0] ext_addr_high
);
   // Compare drive only once software made bit 0 an output
   always_ff @(posedge sys_clk) begin
      timer0_compare_enable <=
         compare_request & portb_bit0_direction;
      timer0_compare_output <= pattern[3];
   end
   // Spi and memory outputs, inverted address so bits differ from pattern
   always_ff @(posedge sys_clk) begin
      spi_clock_output <= pattern[0];
      spi_slave_tx <= pattern[1];
      spi_master_tx <= pattern[2];
      ext_addr_high <= ~pattern;
   end
endmodule

// ==== verif/portb_portc_alt_function_override_tb.sv ====
// Self-checking bench for the port B / port C override logic.
// Assumes 2-cycle pad and 1-cycle override latency, plus 1 in the model.
`timescale 1ns/100ps
module portb_portc_alt_function_override_tb;
   logic sys_clk, rst_b, serial_periph_enable, master_select;
   logic global_pullup_disable, ext_mem_enable, timer0_compare_enable;
   logic timer0_compare_output, spi_clock_output, spi_slave_tx;
   logic spi_master_tx, portb_bit0_direction, compare_request;
   logic timer0_count_input, timer1_count_input, spi_master_rx;
   logic spi_slave_rx, spi_clock_input, spi_slave_select_in;
   logic comparator_pos_input, comparator_neg_input;
   logic [2:0] ext_mem_high_addr_mask;
   logic [7:0] portb_latch, portb_pin, portc_pin, ext_addr_high, pattern;
   logic [7:0] portb_pullup_override_enable, portb_pullup_override_value;
   logic [7:0] portb_direction_override_enable;
   logic [7:0] portb_direction_override_value;
   logic [7:0] portb_pin_value_override_enable;
   logic [7:0] portb_pin_value_override_value;
   logic [7:0] portb_input_enable_override_enable;
   logic [7:0] portb_input_enable_override_value;
   logic [7:0] portc_pullup_override_enable, portc_pullup_override_value;
   logic [7:0] portc_direction_override_enable;
   logic [7:0] portc_direction_override_value;
   logic [7:0] portc_pin_value_override_enable;
   logic [7:0] portc_pin_value_override_value;
   logic [7:0] portc_input_enable_override_enable;
   logic [7:0] portc_input_enable_override_value;
   int error_cnt = 0;
   int checks_done = 0;

   pbpc_override dut (.*);
   pbpc_periph_model model (.*);

   // 100 ns clock
   initial sys_clk = 1'b0;
   always #50 sys_clk = ~sys_clk;

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks=%0d errors=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Whole expected picture worked out from the current inputs
   task automatic check_all();
      logic sm;
      logic [7:0] claim;
      int lim;
      sm = serial_periph_enable & master_select;
      for (int n = 0; n < 8; n++) begin
         lim = (n < 2) ? 7 : 8 - n;
         claim[n] = ext_mem_enable & (int'(ext_mem_high_addr_mask) < lim);
      end
      cmp8(portb_pullup_override_enable, {{4{sm}}, 4'h0});
      cmp8(portb_pullup_override_value,
           {portb_latch[7:4] & {4{global_pullup_disable}}, 4'h0});
      cmp8(portb_direction_override_enable, {{4{sm}}, 4'h0});
      cmp8(portb_direction_override_value, 8'h08);
      cmp8(portb_pin_value_override_enable,
           {{3{sm}}, 4'h0, compare_request & portb_bit0_direction});
      cmp8(portb_pin_value_override_value,
           {pattern[0], pattern[1], pattern[2], 4'h0, pattern[3]});
      cmp8({spi_clock_input, spi_master_rx, spi_slave_rx, spi_slave_select_in,
            comparator_neg_input, comparator_pos_input, timer1_count_input,
            timer0_count_input}, portb_pin);
      cmp8(portc_pullup_override_enable, claim);
      cmp8(portc_direction_override_enable, claim);
      cmp8(portc_pin_value_override_enable, claim);
      cmp8(portc_pullup_override_value, 8'h00);
      cmp8(portc_direction_override_value, 8'hff);
      cmp8(portc_pin_value_override_value, ~pattern);
      cmp8(portb_input_enable_override_enable
           | portb_input_enable_override_value
           | portc_input_enable_override_enable
           | portc_input_enable_override_value, 8'h00);
   endtask

   // Model adds one cycle, the override register one more; pad inputs take two
   task automatic settle_check();
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      check_all();
   endtask

   // Hang guard, well beyond the roughly 125 cycles the tests take
   initial begin
      repeat (1000) @(posedge sys_clk);
      error_cnt++;
      finish_test();
   end

   initial begin
      rst_b = 1'b0;
      {serial_periph_enable, master_select, global_pullup_disable} = 3'h7;
      {ext_mem_enable, portb_bit0_direction, compare_request} = 3'h7;
      ext_mem_high_addr_mask = 3'h0;
      portb_latch = 8'hff;
      portb_pin = 8'h00;
      portc_pin = 8'ha5;
      pattern = 8'h3c;
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk);
      // Outputs held low though every claim is requested
      cmp8(portb_pin_value_override_enable, 8'h00);
      cmp8(portc_pin_value_override_enable, 8'h00);
      $display("test reset done");
      @(posedge sys_clk);
      rst_b <= 1'b1;
      // Every combination of spi enable, master, pull-up and compare
      for (int i = 0; i < 16; i++) begin
         @(posedge sys_clk);
         serial_periph_enable <= i[0];
         master_select <= i[1];
         global_pullup_disable <= i[2];
         compare_request <= i[3];
         portb_bit0_direction <= i[2] ^ i[3];
         portb_latch <= 8'(i * 17) ^ 8'h5a;
         portb_pin <= 8'(i * 37 + 1);
         pattern <= 8'(i * 29 + 3);
         settle_check();
      end
      $display("test port b done");
      // Every mask code with memory enable off and on, back to back
      for (int i = 0; i < 16; i++) begin
         @(posedge sys_clk);
         ext_mem_enable <= i[3];
         ext_mem_high_addr_mask <= i[2:0];
         portc_pin <= 8'(i * 11);
         pattern <= 8'(i * 53 + 7);
         settle_check();
      end
      $display("test port c done");
      // Reset in mid-run clears claims, then traffic resumes
      @(posedge sys_clk);
      rst_b <= 1'b0;
      ext_mem_enable <= 1'b1;
      ext_mem_high_addr_mask <= 3'h0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      cmp8(portc_pullup_override_enable, 8'h00);
      @(posedge sys_clk);
      rst_b <= 1'b1;
      settle_check();
      $display("test mid-run reset done");
      finish_test();
   end
endmodule
